// >>> rtl/acaex_regs.vh
// Constants for the absolute call and add-with-carry execution block
`ifndef ACAEX_REGS_VH
`define ACAEX_REGS_VH
`define ACAEX_CALL_LOW5      5'h11
`define ACAEX_CALL_LOW5_MSB  4
`define ACAEX_ADD_DIRECT_OP  8'h35
`define ACAEX_ADD_IMMED_OP   8'h34
`define ACAEX_ADD_IND_HI     7'h1B
`define ACAEX_ADD_REG_HI     5'h07
`define ACAEX_STACK_RESET    8'h07
`define ACAEX_COUNTER_RESET  16'h0000
`define ACAEX_PAGE_MSB       10
`define ACAEX_PSW_CY         7
`define ACAEX_PSW_BANK_LSB   3
`endif

// >>> rtl/acaex_adder.v
// Eight-bit accumulator adder with carry in
`timescale 1ns/100ps
module acaex_adder
(
  // Operands
  input  wire [7:0] acc_i,
  input  wire [7:0] src_i,
  input  wire       cy_i,
  // Result
  output wire [7:0] sum_o
);
  // Carry out is not kept: flag updates belong to another block
  assign sum_o = acc_i + src_i + {7'h00, cy_i};
endmodule // acaex_adder

// >>> rtl/acaex_core.v
// Execution of absolute call and add-with-carry instructions
// Function
// - Call adds two to program counter, pushes 16-bit return low byte first.
// - Stack pointer increments before each of the two pushes, ending two higher.
// - Call target is incremented counter bits 15-11, opcode bits 7-5, second byte.
// - Call leaves all status flags unchanged.
// - Call is two bytes long and takes two machine cycles; here three clocks.
// - Call is decoded by low five opcode bits equal to 10001.
// - Add-with-carry loads accumulator with accumulator plus carry plus source.
// - Direct form opcode 35h, second byte is address, one cycle; here four clocks.
// - Immediate form opcode 34h, second byte is constant, one cycle; here two clocks.
`timescale 1ns/100ps
`include "acaex_regs.vh"
module acaex_core
(
  // Clock and reset
  input  wire        core_clk_i,
  input  wire        resetn_i,
  // Program memory fetch
  input  wire        code_valid_i,
  input  wire [7:0]  code_byte_i,
  output reg  [15:0] code_addr_o,
  // Internal data RAM
  input  wire [7:0]  ram_rdata_i,
  output reg  [7:0]  ram_addr_o,
  output reg  [7:0]  ram_wdata_o,
  output reg         ram_we_o,
  // Architectural state
  input  wire [7:0]  psw_i,
  output reg  [7:0]  acc_o,
  output reg  [7:0]  stack_pointer_o,
  output reg  [15:0] program_counter_o,
  output reg         psw_we_o,
  output reg         illegal_o,
  output reg         busy_o
);
  localparam [2:0] ST_OP    = 3'h0;
  localparam [2:0] ST_ARG   = 3'h1;
  localparam [2:0] ST_RD    = 3'h2;
  localparam [2:0] ST_PTR   = 3'h3;
  localparam [2:0] ST_PUSHL = 3'h4;
  localparam [2:0] ST_PUSHH = 3'h5;
  localparam [2:0] ST_ADD   = 3'h6;

  function is_call;
    input [7:0] op;
    begin
      is_call = (op[`ACAEX_CALL_LOW5_MSB:0] == `ACAEX_CALL_LOW5);
    end
  endfunction

  function is_dir;
    input [7:0] op;
    begin
      is_dir = (op == `ACAEX_ADD_DIRECT_OP);
    end
  endfunction

  function is_imm;
    input [7:0] op;
    begin
      is_imm = (op == `ACAEX_ADD_IMMED_OP);
    end
  endfunction

  function [7:0] bank_addr;
    input [7:0] psw;
    input [2:0] idx;
    begin
      bank_addr = {3'h0, psw[`ACAEX_PSW_BANK_LSB+1:`ACAEX_PSW_BANK_LSB], idx};
    end
  endfunction

  reg  [2:0]  st_ff;
  reg  [7:0]  op_ff;
  reg  [7:0]  opnd_ff;
  reg  [15:0] ret_ff;
  wire [7:0]  sum;
  wire [7:0]  add_src;
  wire [15:0] nxt_ret;
  wire [15:0] step_addr;

  assign nxt_ret   = program_counter_o + 16'h0002;
  assign step_addr = program_counter_o + 16'h0001;
  // Immediate data goes through the same adder as the RAM operands
  assign add_src   = (st_ff == ST_ARG) ? code_byte_i : opnd_ff;

  acaex_adder u_add
  (
    .acc_i (acc_o),
    .src_i (add_src),
    .cy_i  (psw_i[`ACAEX_PSW_CY]),
    .sum_o (sum)
  );

  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_ff             <= ST_OP;
      op_ff             <= 8'h00;
      opnd_ff           <= 8'h00;
      ret_ff            <= 16'h0000;
      code_addr_o       <= `ACAEX_COUNTER_RESET;
      program_counter_o <= `ACAEX_COUNTER_RESET;
      ram_addr_o        <= 8'h00;
      ram_wdata_o       <= 8'h00;
      ram_we_o          <= 1'b0;
      acc_o             <= 8'h00;
      stack_pointer_o   <= `ACAEX_STACK_RESET;
      psw_we_o          <= 1'b0;
      illegal_o         <= 1'b0;
      busy_o            <= 1'b0;
    end
    else
    begin
      ram_we_o  <= 1'b0;
      psw_we_o  <= 1'b0;
      illegal_o <= 1'b0;
      case (st_ff)
        ST_OP:
        begin
          if (code_valid_i)
          begin
            op_ff  <= code_byte_i;
            busy_o <= 1'b1;
            // Two-byte forms fetch their second byte before anything else
            if (is_call(code_byte_i) || is_dir(code_byte_i) || is_imm(code_byte_i))
            begin
              code_addr_o <= step_addr;
              st_ff       <= ST_ARG;
            end
            else if (code_byte_i[7:3] == `ACAEX_ADD_REG_HI)
            begin
              ram_addr_o <= bank_addr(psw_i, code_byte_i[2:0]);
              st_ff      <= ST_RD;
            end
            else if (code_byte_i[7:1] == `ACAEX_ADD_IND_HI)
            begin
              ram_addr_o <= bank_addr(psw_i, {2'b00, code_byte_i[0]});
              st_ff      <= ST_PTR;
            end
            else
            begin
              // Unsupported opcodes are skipped as one byte so fetch keeps moving
              illegal_o         <= 1'b1;
              busy_o            <= 1'b0;
              program_counter_o <= step_addr;
              code_addr_o       <= step_addr;
            end
          end
        end
        ST_ARG:
        begin
          if (code_valid_i)
          begin
            if (is_call(op_ff))
            begin
              ret_ff            <= nxt_ret;
              program_counter_o <= {nxt_ret[15:11], op_ff[7:5], code_byte_i};
              stack_pointer_o   <= stack_pointer_o + 8'h01;
              ram_addr_o        <= stack_pointer_o + 8'h01;
              ram_wdata_o       <= nxt_ret[7:0];
              ram_we_o          <= 1'b1;
              st_ff             <= ST_PUSHH;
            end
            else if (is_imm(op_ff))
            begin
              acc_o             <= sum;
              program_counter_o <= nxt_ret;
              code_addr_o       <= nxt_ret;
              busy_o            <= 1'b0;
              st_ff             <= ST_OP;
            end
            else
            begin
              ram_addr_o <= code_byte_i;
              st_ff      <= ST_RD;
            end
          end
        end
        ST_PTR:
        begin
          ram_addr_o <= ram_rdata_i;
          st_ff      <= ST_RD;
        end
        ST_RD:
        begin
          opnd_ff <= ram_rdata_i;
          st_ff   <= ST_ADD;
        end
        ST_ADD:
        begin
          acc_o  <= sum;
          busy_o <= 1'b0;
          st_ff  <= ST_OP;
          // Direct form is two bytes long, register and indirect forms one
          if (is_dir(op_ff))
          begin
            program_counter_o <= nxt_ret;
            code_addr_o       <= nxt_ret;
          end
          else
          begin
            program_counter_o <= step_addr;
            code_addr_o       <= step_addr;
          end
        end
        ST_PUSHH:
        begin
          stack_pointer_o <= stack_pointer_o + 8'h01;
          ram_addr_o      <= stack_pointer_o + 8'h01;
          ram_wdata_o     <= ret_ff[15:8];
          ram_we_o        <= 1'b1;
          code_addr_o     <= program_counter_o;
          busy_o          <= 1'b0;
          st_ff           <= ST_OP;
        end
        default:
        begin
          st_ff <= ST_OP;
        end
      endcase
    end
  end
endmodule // acaex_core

// >>> tb/acaex_chk.sv
// Assertions on the call and add-with-carry block
`timescale 1ns/100ps
module acaex_chk
(
  // Watched ports
  input wire        core_clk_i,
  input wire        resetn_i,
  input wire        ram_we_o,
  input wire [7:0]  ram_addr_o,
  input wire [7:0]  ram_wdata_o,
  input wire [7:0]  stack_pointer_o,
  input wire [15:0] program_counter_o,
  input wire [7:0]  acc_o,
  input wire        psw_we_o,
  input wire        busy_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_push_addr: assert property (ram_we_o |-> ram_addr_o == stack_pointer_o)
    else $error("push address off");
  a_sp_step: assert property (ram_we_o |-> stack_pointer_o == $past(stack_pointer_o) + 8'h01)
    else $error("pointer step wrong");
  a_sp_still: assert property (!ram_we_o |-> $stable(stack_pointer_o))
    else $error("pointer moved");
  a_push_pair: assert property (ram_we_o ##1 ram_we_o |=> !ram_we_o)
    else $error("extra push");
  a_page_keep: assert property ($rose(ram_we_o) |=> ram_wdata_o[7:3] == program_counter_o[15:11])
    else $error("page left");
  a_call_len: assert property ($rose(ram_we_o) |=> ram_we_o && !busy_o)
    else $error("call length wrong");
  a_flags_keep: assert property (!psw_we_o)
    else $error("flags written");
  a_acc_hold: assert property (ram_we_o |-> $stable(acc_o))
    else $error("acc moved in call");
endmodule // acaex_chk
bind acaex_core acaex_chk chk_u (.core_clk_i, .resetn_i, .ram_we_o, .ram_addr_o, .ram_wdata_o,
  .stack_pointer_o, .program_counter_o, .acc_o, .psw_we_o, .busy_o);

// >>> tb/acaex_mem.sv
// Program memory and internal data RAM model
`timescale 1ns/100ps
module acaex_mem
(
  // Fetch side
  input  wire        core_clk_i,
  input  wire        slow_i,
  input  wire [15:0] code_addr_i,
  output wire        code_valid_o,
  output wire [7:0]  code_byte_o,
  // Data side
  input  wire [7:0]  ram_addr_i,
  input  wire [7:0]  ram_wdata_i,
  input  wire        ram_we_i,
  output wire [7:0]  ram_rdata_o
);
  logic [7:0] rom [0:65535];
  logic [7:0] ram [0:255];
  assign code_valid_o = !slow_i;
  // Stalled fetch shows a wrong byte so a stale read is caught
  assign code_byte_o = slow_i ? ~rom[code_addr_i] : rom[code_addr_i];
  assign ram_rdata_o = ram[ram_addr_i];
  always @(posedge core_clk_i)
    if (ram_we_i)
      ram[ram_addr_i] <= ram_wdata_i;
endmodule // acaex_mem

// >>> tb/testbench.sv
// Self-checking bench for the call and add-with-carry block
`timescale 1ns/100ps
module testbench;
  logic       core_clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       slow = 1'b0;
  logic [7:0] psw_i = 8'h88;
  wire        code_valid_i, ram_we_o, psw_we_o, illegal_o, busy_o;
  wire [7:0]  code_byte_i, ram_rdata_i, ram_addr_o, ram_wdata_o, acc_o, stack_pointer_o;
  wire [15:0] code_addr_o, program_counter_o;
  int         mismatches = 0;
  int         num_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  acaex_core dut_u (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .code_valid_i(code_valid_i),
    .code_byte_i(code_byte_i), .code_addr_o(code_addr_o), .ram_rdata_i(ram_rdata_i),
    .ram_addr_o(ram_addr_o), .ram_wdata_o(ram_wdata_o), .ram_we_o(ram_we_o), .psw_i(psw_i),
    .acc_o(acc_o), .stack_pointer_o(stack_pointer_o), .program_counter_o(program_counter_o),
    .psw_we_o(psw_we_o), .illegal_o(illegal_o), .busy_o(busy_o));
  acaex_mem mem_u (.core_clk_i, .slow_i(slow), .code_addr_i(code_addr_o),
    .code_valid_o(code_valid_i), .code_byte_o(code_byte_i), .ram_addr_i(ram_addr_o),
    .ram_wdata_i(ram_wdata_o), .ram_we_i(ram_we_o), .ram_rdata_o(ram_rdata_i));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task run_to(input logic [15:0] a);
    for (int n = 0; n < 40 && (program_counter_o !== a || busy_o !== 1'b0); n++)
    begin
      @(posedge core_clk_i);
      #1;
    end
    if (program_counter_o !== a || busy_o !== 1'b0)
    begin
      // An instruction that never finishes counts as a mismatch of its own
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, program_counter_o, a);
    end
  endtask
  task t_add_with_carry;
    run_to(16'h0002);
    chk(acc_o, 8'h11);
    run_to(16'h0004);
    chk(acc_o, 8'h17);
    run_to(16'h0005);
    chk(acc_o, 8'h1B);
    run_to(16'h0006);
    chk(acc_o, 8'h5C);
  endtask
  task call_chk(input logic [15:0] tgt, input logic [7:0] s, input logic [15:0] ret);
    run_to(tgt);
    chk(stack_pointer_o, s);
    chk(code_addr_o, tgt);
    chk(mem_u.ram[s - 8'h01], ret[7:0]);
    // The high byte lands in RAM one edge after its write strobe
    @(posedge core_clk_i);
    #1;
    chk(mem_u.ram[s], ret[15:8]);
  endtask
  task t_calls;
    @(posedge core_clk_i);
    slow <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    slow <= 1'b0;
    call_chk(16'h0145, 8'h09, 16'h0008);
    call_chk(16'h07FF, 8'h0B, 16'h0147);
    call_chk(16'h0B80, 8'h0D, 16'h0801);
  endtask
  // Runs straight on from the last call: its target holds an unsupported opcode
  task t_skip;
    chk(illegal_o, 16'h0001);
    chk(program_counter_o, 16'h0B81);
    chk(stack_pointer_o, 8'h0D);
    @(posedge core_clk_i);
    psw_i <= 8'h00;
    run_to(16'h0B83);
    chk(illegal_o, 16'h0000);
    chk(acc_o, 8'hFF);
  endtask
  task stop_test;
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    mem_u.rom[0] = 8'h34;
    mem_u.rom[1] = 8'h10;
    mem_u.rom[2] = 8'h35;
    mem_u.rom[3] = 8'h20;
    mem_u.rom[4] = 8'h3F;
    mem_u.rom[5] = 8'h37;
    mem_u.rom[6] = 8'h31;
    mem_u.rom[7] = 8'h45;
    mem_u.rom[16'h0145] = 8'hF1;
    mem_u.rom[16'h0146] = 8'hFF;
    mem_u.rom[16'h07FF] = 8'h71;
    mem_u.rom[16'h0800] = 8'h80;
    mem_u.rom[16'h0B80] = 8'h00;
    mem_u.rom[16'h0B81] = 8'h34;
    mem_u.rom[16'h0B82] = 8'hA3;
    mem_u.ram[8'h20] = 8'h05;
    mem_u.ram[8'h0F] = 8'h03;
    mem_u.ram[8'h09] = 8'h30;
    mem_u.ram[8'h30] = 8'h40;
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_add_with_carry;
    t_calls;
    t_skip;
    stop_test;
  end
  initial
  begin
    #3000;
    mismatches++;
    stop_test;
  end
endmodule // testbench
